// File: mrm_report_mode.sv
// Mouse report mode logic: command interpreter, report formatter, buffer and link crossing
// How it works
// - status byte one carries mode and scaling flags
// - status byte one low bits show buttons
// - status bytes two, three: resolution, rate
// - standard PS/2 report is three bytes
// - movement nine-bit, wheel eight-bit two's complement
// - 3D PS/2 adds fourth byte with wheel
// - five-button PS/2: no overflow, extra buttons
// - PS/2 right, up, toward user positive
// - rates C8, 64, 50 select 3D; ID 03
// - rates C8, C8, 50 select five-button; ID 04
// - variant limits which wheel mode is reachable
// - reset command returns to standard mode
// - power-on reset starts in standard mode
// - USB 3D report is four bytes
// - USB five-button byte one holds extra buttons
// - USB up and toward user negative

// Buffer between report formatter and link crossing
module mrm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [CW-1:0] count;
	} mrm_fifo_t;
	mrm_fifo_t q, d;
	logic push, pop;

	// Handshakes on both sides
	assign o_in_ready = (q.count != FULL);
	assign o_out_valid = (q.count != '0);
	assign o_out_data = q.mem[q.rptr];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	// Pointer and count update
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wptr] = i_in_data;
			d.wptr = (q.wptr == LAST) ? '0 : AW'(q.wptr + 1'b1);
		end
		if (pop) begin
			d.rptr = (q.rptr == LAST) ? '0 : AW'(q.rptr + 1'b1);
		end
		if (push && !pop) begin
			d.count = CW'(q.count + 1'b1);
		end else if (pop && !push) begin
			d.count = CW'(q.count - 1'b1);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : mrm_fifo

// Top: system-clock interpreter and formatter, link-clock byte exchange
module mrm_report_mode (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_link_clock,
	input wire logic i_link_rx_valid,
	input wire logic [7:0] i_link_rx_byte,
	input wire logic i_link_tx_ready,
	output logic o_link_tx_valid,
	output logic [7:0] o_link_tx_byte,
	input wire logic i_five_button_variant,
	input wire logic i_usb_host,
	input wire logic [4:0] i_button_n,
	input wire logic i_motion_valid,
	input wire logic [7:0] i_dx,
	input wire logic [7:0] i_dy,
	input wire logic [7:0] i_dz,
	input wire logic i_report_req,
	input wire logic i_status_req,
	input wire logic i_remote_mode,
	input wire logic i_report_enable,
	input wire logic i_scaling_2to1,
	input wire logic i_wrap_mode,
	input wire logic [7:0] i_resolution,
	output mrm_pkg::mrm_mode_t o_report_mode,
	output logic [7:0] o_sample_rate
);
	import mrm_pkg::*;

	typedef struct packed {
		logic [4:0] btn_s1;
		logic [4:0] btn_s2;
		logic rx_s1;
		logic rx_s2;
		logic rx_s3;
		logic ack_s1;
		logic ack_s2;
		logic ack_s3;
		mrm_mode_t mode;
		logic [7:0] rate;
		logic expect_rate;
		logic [1:0] stage;
		logic cmd_pend;
		logic rep_pend;
		logic st_pend;
		logic [9:0] acc_x;
		logic [9:0] acc_y;
		logic [9:0] acc_z;
		logic ovf_x;
		logic ovf_y;
		mrm_em_t em;
		logic [3:0][7:0] out;
		logic [2:0] out_n;
		logic [1:0] out_i;
		logic tx_busy;
		logic tx_req;
		logic [7:0] tx_byte;
	} mrm_sys_t;

	typedef struct packed {
		logic rx_tgl;
		logic [7:0] rx_byte;
		logic req_s1;
		logic req_s2;
		logic req_s3;
		logic tx_valid;
		logic [7:0] tx_byte;
		logic ack_tgl;
	} mrm_link_t;

	mrm_sys_t q, d;
	mrm_link_t lq, ld;
	logic idle, ld_cmd, ld_st, ld_rep;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [7:0] fifo_out_data;
	logic [4:0] btn;
	logic [7:0] cmd;

	// Add a motion step to an accumulator; top bit flags a clamp
	function automatic logic [10:0] acc_add(input logic [9:0] a, input logic [7:0] s);
		logic [10:0] t;
		t = {a[9], a} + {{3{s[7]}}, s};
		if ($signed(t) > $signed({1'b0, MOVE_MAX})) begin
			return {1'b1, MOVE_MAX};
		end else if ($signed(t) < $signed({1'b1, MOVE_MIN})) begin
			return {1'b1, MOVE_MIN};
		end
		return {1'b0, t[9:0]};
	endfunction : acc_add

	// Saturate a ten-bit movement to eight bits
	function automatic logic [7:0] sat8(input logic [9:0] v);
		if ($signed(v) > $signed(SAT8_MAX)) begin
			return SAT8_MAX[7:0];
		end else if ($signed(v) < $signed(SAT8_MIN)) begin
			return SAT8_MIN[7:0];
		end
		return v[7:0];
	endfunction : sat8

	// Source selection for the byte emitter, commands first
	assign idle = (q.em == EM_IDLE);
	assign ld_cmd = idle && q.cmd_pend;
	assign ld_st = idle && !q.cmd_pend && q.st_pend;
	assign ld_rep = idle && !q.cmd_pend && !q.st_pend && q.rep_pend;
	assign btn = ~q.btn_s2;
	assign cmd = lq.rx_byte; // Held in the link capture register until the next host byte
	assign fifo_out_ready = !q.tx_busy;

	// System domain next state
	always_comb begin
		logic [10:0] nx, ny, nz;
		logic [7:0] zs, z4, ex;
		nx = '0;
		ny = '0;
		nz = '0;
		zs = '0;
		z4 = '0;
		ex = '0;
		d = q;
		d.btn_s1 = i_button_n;
		d.btn_s2 = q.btn_s1;
		d.rx_s1 = lq.rx_tgl;
		d.rx_s2 = q.rx_s1;
		d.rx_s3 = q.rx_s2;
		d.ack_s1 = lq.ack_tgl;
		d.ack_s2 = q.ack_s1;
		d.ack_s3 = q.ack_s2;
		// Movement accumulation, restarted when a report is taken
		if (i_motion_valid) begin
			nx = acc_add(ld_rep ? '0 : q.acc_x, i_dx);
			ny = acc_add(ld_rep ? '0 : q.acc_y, i_dy);
			nz = acc_add(ld_rep ? '0 : q.acc_z, i_dz);
			d.acc_x = nx[9:0];
			d.acc_y = ny[9:0];
			d.acc_z = nz[9:0];
			d.ovf_x = nx[10] || (q.ovf_x && !ld_rep);
			d.ovf_y = ny[10] || (q.ovf_y && !ld_rep);
		end else if (ld_rep) begin
			d.acc_x = '0;
			d.acc_y = '0;
			d.acc_z = '0;
			d.ovf_x = 1'b0;
			d.ovf_y = 1'b0;
		end
		// Pending requests; a new request wins over the clear
		d.cmd_pend = (q.cmd_pend && !ld_cmd) || (q.rx_s2 ^ q.rx_s3);
		d.st_pend = (q.st_pend && !ld_st) || i_status_req;
		d.rep_pend = (q.rep_pend && !ld_rep) || i_report_req;
		// Command interpretation
		if (ld_cmd) begin
			d.out[0] = RSP_ACK;
			d.out_n = 3'h1;
			d.em = EM_PUSH;
			d.out_i = '0;
			if (cmd == CMD_RESET) begin
				d.mode = MRM_STD;
				d.stage = '0;
				d.expect_rate = 1'b0;
				d.rate = RATE_DEFAULT;
			end else if (q.expect_rate) begin
				d.rate = cmd;
				d.expect_rate = 1'b0;
				ex = (q.stage == 2'h0) ? RATE_FIRST :
					(q.stage == 2'h1) ? (i_five_button_variant ? RATE_FIRST : RATE_3D) :
					RATE_END;
				if (q.stage == 2'h2 && cmd == RATE_END) begin
					d.mode = i_five_button_variant ? MRM_FIVE : MRM_3D;
					d.stage = '0;
				end else if (cmd == ex) begin
					d.stage = 2'(q.stage + 1'b1);
				end else begin
					d.stage = (cmd == RATE_FIRST) ? 2'h1 : 2'h0;
				end
			end else if (cmd == CMD_SET_RATE) begin
				d.expect_rate = 1'b1;
			end else if (cmd == CMD_READ_ID) begin
				d.out_n = 3'h2;
				d.out[1] = (q.mode == MRM_3D) ? ID_3D : (q.mode == MRM_FIVE) ? ID_FIVE : ID_STD;
			end
		end
		// Status bytes
		if (ld_st) begin
			d.out[0] = '0;
			d.out[0][ST_REMOTE] = i_remote_mode;
			d.out[0][ST_ENABLE] = i_report_enable;
			d.out[0][ST_SCALE] = i_scaling_2to1;
			d.out[0][ST_WRAP] = i_wrap_mode;
			d.out[0][ST_LEFT] = btn[BTN_L];
			d.out[0][ST_MID] = btn[BTN_M];
			d.out[0][ST_RIGHT] = btn[BTN_R];
			d.out[1] = i_resolution;
			d.out[2] = q.rate;
			d.out_n = 3'h3;
			d.out_i = '0;
			d.em = EM_PUSH;
		end
		// Movement and button reports
		if (ld_rep) begin
			zs = sat8(q.acc_z);
			z4 = ($signed(zs) > $signed(Z4_MAX)) ? Z4_MAX :
				($signed(zs) < $signed(Z4_MIN)) ? Z4_MIN : zs;
			d.out_i = '0;
			d.em = EM_PUSH;
			if (i_usb_host) begin
				d.out_n = 3'h4;
				d.out[0] = {5'h00, btn[BTN_M], btn[BTN_R], btn[BTN_L]};
				if (i_five_button_variant) begin
					d.out[0][4:3] = {btn[BTN_5], btn[BTN_4]};
				end
				d.out[1] = sat8(q.acc_x);
				d.out[2] = sat8(10'(-q.acc_y));
				d.out[3] = sat8(10'(-q.acc_z));
			end else begin
				d.out[0] = {q.ovf_y, q.ovf_x, q.acc_y[8], q.acc_x[8],
					1'b1, btn[BTN_M], btn[BTN_R], btn[BTN_L]};
				d.out[1] = q.acc_x[7:0];
				d.out[2] = q.acc_y[7:0];
				d.out[3] = zs;
				d.out_n = (q.mode == MRM_STD) ? 3'h3 : 3'h4;
				if (q.mode == MRM_FIVE) begin
					d.out[0][7:6] = 2'b00;
					d.out[3] = {2'b00, btn[BTN_5], btn[BTN_4], z4[3:0]};
				end
			end
		end
		// Push loaded bytes into the buffer, stalling while it is full
		if (q.em == EM_PUSH && fifo_in_ready) begin
			d.out_i = 2'(q.out_i + 1'b1);
			if ({1'b0, q.out_i} == 3'(q.out_n - 3'h1)) begin
				d.em = EM_IDLE;
			end
		end
		// Hand one byte at a time to the link domain
		if (q.ack_s2 ^ q.ack_s3) begin
			d.tx_busy = 1'b0;
		end
		if (!q.tx_busy && fifo_out_valid) begin
			d.tx_byte = fifo_out_data;
			d.tx_req = !q.tx_req;
			d.tx_busy = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= '0;
			q.btn_s1 <= 5'h1F;
			q.btn_s2 <= 5'h1F;
			q.mode <= MRM_STD;
			q.rate <= RATE_DEFAULT;
			q.em <= EM_IDLE;
		end else begin
			q <= d;
		end
	end

	mrm_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_in_valid(q.em == EM_PUSH),
		.o_in_ready(fifo_in_ready),
		.i_in_data(q.out[q.out_i]),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(fifo_out_ready),
		.o_out_data(fifo_out_data)
	);

	// Link domain: capture host bytes, present device bytes
	always_comb begin
		ld = lq;
		ld.req_s1 = q.tx_req;
		ld.req_s2 = lq.req_s1;
		ld.req_s3 = lq.req_s2;
		if (i_link_rx_valid) begin
			ld.rx_byte = i_link_rx_byte;
			ld.rx_tgl = !lq.rx_tgl;
		end
		if (lq.tx_valid && i_link_tx_ready) begin
			ld.tx_valid = 1'b0;
			ld.ack_tgl = !lq.ack_tgl;
		end
		if (lq.req_s2 ^ lq.req_s3) begin
			ld.tx_valid = 1'b1;
			ld.tx_byte = q.tx_byte; // Stable while the request is open
		end
	end

	always_ff @(posedge i_link_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lq <= '0;
		end else begin
			lq <= ld;
		end
	end

	assign o_link_tx_valid = lq.tx_valid;
	assign o_link_tx_byte = lq.tx_byte;
	assign o_report_mode = q.mode;
	assign o_sample_rate = q.rate;

	// Checks on the system domain
	a_reset_to_std: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		ld_cmd && cmd == CMD_RESET |=> q.mode == MRM_STD && q.out[0] == RSP_ACK)
		else $error("reset command did not restore standard mode");
	a_id_3d: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		ld_cmd && cmd == CMD_READ_ID && !q.expect_rate && q.mode == MRM_3D
		|=> q.out_n == 3'h2 && q.out[1] == ID_3D)
		else $error("read ID in 3D mode gave wrong answer");
	a_id_five: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		ld_cmd && cmd == CMD_READ_ID && !q.expect_rate && q.mode == MRM_FIVE
		|=> q.out_n == 3'h2 && q.out[1] == ID_FIVE)
		else $error("read ID in five-button mode gave wrong answer");
	a_variant_lock: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		q.mode != MRM_FIVE ##1 q.mode == MRM_FIVE |-> $past(i_five_button_variant))
		else $error("three-button variant entered five-button mode");
	a_mode_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		ld_cmd && q.expect_rate && cmd != RATE_END && cmd != CMD_RESET |=> $stable(q.mode))
		else $error("mode changed on unmatched rate");
	a_ps2_layout: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		ld_rep && !i_usb_host && q.mode == MRM_STD
		|=> q.out_n == 3'h3 && q.out[0][PS_MARK] && q.out[0][4] == $past(q.acc_x[8]))
		else $error("standard PS/2 report malformed");
	a_five_top: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		ld_rep && !i_usb_host && q.mode == MRM_FIVE
		|=> q.out_n == 3'h4 && q.out[0][7:6] == 2'b00 && q.out[3][7:6] == 2'b00)
		else $error("five-button PS/2 report malformed");
	a_usb_layout: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		ld_rep && i_usb_host |=> q.out_n == 3'h4 && q.out[0][7:5] == 3'h0
		&& q.out[1] == sat8($past(q.acc_x)))
		else $error("USB report malformed");
	a_status_rate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		ld_st |=> q.out_n == 3'h3 && q.out[2] == $past(q.rate) && q.em == EM_PUSH)
		else $error("status bytes malformed");
	// Check on the link domain
	a_tx_hold: assert property (@(posedge i_link_clock) disable iff (!i_rst_n)
		lq.tx_valid && !i_link_tx_ready |=> lq.tx_valid && $stable(lq.tx_byte))
		else $error("link byte dropped before it was taken");
endmodule : mrm_report_mode

// File: mrm_pkg.sv
// Constants and types shared by the mouse report mode logic
package mrm_pkg;
	// Host command bytes and device answers
	localparam logic [7:0] CMD_SET_RATE = 8'hF3;
	localparam logic [7:0] CMD_READ_ID = 8'hF2;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] RSP_ACK = 8'hFA;
	localparam logic [7:0] ID_STD = 8'h00;
	localparam logic [7:0] ID_3D = 8'h03;
	localparam logic [7:0] ID_FIVE = 8'h04;
	// Rate values that form the mode-entry sequences, and the reset rate
	localparam logic [7:0] RATE_FIRST = 8'hC8;
	localparam logic [7:0] RATE_3D = 8'h64;
	localparam logic [7:0] RATE_END = 8'h50;
	localparam logic [7:0] RATE_DEFAULT = 8'h64;
	// Status byte one field positions
	localparam int ST_REMOTE = 6;
	localparam int ST_ENABLE = 5;
	localparam int ST_SCALE = 4;
	localparam int ST_WRAP = 3;
	localparam int ST_LEFT = 2;
	localparam int ST_MID = 1;
	localparam int ST_RIGHT = 0;
	// Constant one in PS/2 report byte one
	localparam int PS_MARK = 3;
	// Button indices on the button input vector
	localparam int BTN_L = 0;
	localparam int BTN_R = 1;
	localparam int BTN_M = 2;
	localparam int BTN_4 = 3;
	localparam int BTN_5 = 4;
	// Output buffer shape
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 4;
	// Clamp limits, two's complement: ten-bit, except the eight-bit wheel nibble limits
	localparam logic [9:0] MOVE_MAX = 10'h0FF;
	localparam logic [9:0] MOVE_MIN = 10'h300;
	localparam logic [9:0] SAT8_MAX = 10'h07F;
	localparam logic [9:0] SAT8_MIN = 10'h380;
	localparam logic [7:0] Z4_MAX = 8'h07;
	localparam logic [7:0] Z4_MIN = 8'hF8;
	typedef enum logic [2:0] {
		MRM_STD = 3'b001,
		MRM_3D = 3'b010,
		MRM_FIVE = 3'b100
	} mrm_mode_t;
	typedef enum logic [1:0] {
		EM_IDLE = 2'b01,
		EM_PUSH = 2'b10
	} mrm_em_t;
endpackage : mrm_pkg

// File: mrm_host_model.sv
// Host side model: sends command bytes over the link and takes device bytes
module mrm_host_model (
	input wire logic i_link_clock,
	input wire logic i_rst_n,
	input wire logic i_send,
	input wire logic [7:0] i_send_byte,
	input wire logic i_slow,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_byte,
	output logic o_rx_valid,
	output logic [7:0] o_rx_byte,
	output logic o_tx_ready,
	output logic o_got,
	output logic [7:0] o_got_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] pace_q;
	// One-cycle strobe per host byte; the data line wanders while idle
	always_ff @(posedge i_link_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rx_valid <= 1'b0;
			o_rx_byte <= 8'h00;
			pace_q <= 2'h0;
			o_got <= 1'b0;
			o_got_byte <= 8'h00;
		end else begin
			o_rx_valid <= i_send;
			o_rx_byte <= i_send ? i_send_byte : ~o_rx_byte;
			pace_q <= pace_q + 2'h1;
			o_got <= i_tx_valid & o_tx_ready;
			o_got_byte <= i_tx_byte;
		end
	end
	// Slow host takes a byte only every fourth link cycle
	assign o_tx_ready = i_rst_n & (!i_slow | (pace_q == 2'h3));
endmodule : mrm_host_model

// File: tb_top.sv
// Self-checking bench for the mouse report mode logic
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import mrm_pkg::*;
	logic i_clock = 0, lclk = 0, i_rst_n = 0, five = 0, usb = 0, mv = 0, rep = 0, st = 0;
	logic rem = 0, en = 0, scl = 0, wrp = 0, send = 0, slow = 0;
	logic [4:0] btn_n = 5'h1F;
	logic [7:0] dx = 0, dy = 0, dz = 0, res = 0, sbyte = 0, eb, erate;
	logic rxv, txr, txv, got;
	logic [7:0] rxb, txb, gotb, rate;
	mrm_mode_t mode, emode;
	logic [7:0] exq[$];
	int mismatches = 0, n_tests = 0, ax = 0, ay = 0, az = 0;
	int seed = 32'h3c0979e9;
	logic xv = 0, yv = 0;
	mrm_report_mode u_mrm_report_mode (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_link_clock(lclk), .i_link_rx_valid(rxv), .i_link_rx_byte(rxb),
		.i_link_tx_ready(txr), .o_link_tx_valid(txv), .o_link_tx_byte(txb),
		.i_five_button_variant(five), .i_usb_host(usb), .i_button_n(btn_n),
		.i_motion_valid(mv), .i_dx(dx), .i_dy(dy), .i_dz(dz), .i_report_req(rep),
		.i_status_req(st), .i_remote_mode(rem), .i_report_enable(en),
		.i_scaling_2to1(scl), .i_wrap_mode(wrp), .i_resolution(res),
		.o_report_mode(mode), .o_sample_rate(rate));
	mrm_host_model u_mrm_host_model (.i_link_clock(lclk), .i_rst_n(i_rst_n), .i_send(send),
		.i_send_byte(sbyte), .i_slow(slow), .i_tx_valid(txv), .i_tx_byte(txb),
		.o_rx_valid(rxv), .o_rx_byte(rxb), .o_tx_ready(txr), .o_got(got), .o_got_byte(gotb));
	// System clock 20 ns, link clock 80 ns with its own phase
	initial begin
		forever #10 i_clock = ~i_clock;
	end
	initial begin
		#7;
		forever #40 lclk = ~lclk;
	end
	// Each device byte taken by the host is matched with the oldest note
	always @(posedge lclk) begin
		if (got === 1'b1) begin
			if (exq.size() == 0) begin
				mismatches++;
				$display("CHECK FAILED link byte exp none got %h", gotb);
			end else begin
				eb = exq.pop_front();
				`CHK("link byte", eb, gotb)
			end
		end
	end
	task automatic close_out();
		$display("Compares %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	// Waits until every noted byte has been taken, bounded
	task automatic drain();
		int k;
		k = 0;
		while ((exq.size() != 0 || txv !== 1'b0) && k < 4000) begin
			@(posedge i_clock);
			k++;
		end
		if (k >= 4000) begin
			mismatches++;
			close_out();
		end
		repeat (4) @(posedge i_clock);
	endtask : drain
	// One host byte; acknowledge always, identity after read-ID
	task automatic host(logic [7:0] b, logic [7:0] id);
		exq.push_back(RSP_ACK);
		if (b == CMD_READ_ID) exq.push_back(id);
		@(posedge lclk);
		send <= 1'b1;
		sbyte <= b;
		@(posedge lclk);
		send <= 1'b0;
		drain();
	endtask : host
	task automatic seq(logic [7:0] a, logic [7:0] b, logic [7:0] c);
		logic [7:0] r[3];
		r = '{a, b, c};
		foreach (r[i]) begin
			host(CMD_SET_RATE, 8'h00);
			host(r[i], 8'h00);
		end
		erate = c;
	endtask : seq
	task automatic rnd();
		@(posedge i_clock);
		{rem, en, scl, wrp} <= 4'($random(seed));
		res <= 8'($random(seed));
		btn_n <= 5'($random(seed));
		repeat (4) @(posedge i_clock);
	endtask : rnd
	// Motion step and the accumulation the device should make of it
	task automatic move(logic [7:0] x, logic [7:0] y, logic [7:0] z);
		@(posedge i_clock);
		mv <= 1'b1;
		{dx, dy, dz} <= {x, y, z};
		@(posedge i_clock);
		mv <= 1'b0;
		ax += int'($signed(x));
		ay += int'($signed(y));
		az += int'($signed(z));
		if (ax > 255 || ax < -256) xv = 1'b1;
		if (ay > 255 || ay < -256) yv = 1'b1;
		ax = (ax > 255) ? 255 : (ax < -256) ? -256 : ax;
		ay = (ay > 255) ? 255 : (ay < -256) ? -256 : ay;
		az = (az > 255) ? 255 : (az < -256) ? -256 : az; // Wheel shares the nine-bit clamp
	endtask : move
	function automatic logic [7:0] s8(int v);
		return (v > 127) ? 8'h7F : (v < -128) ? 8'h80 : 8'(v);
	endfunction : s8
	task automatic report();
		logic [8:0] x9, y9;
		logic [2:0] m;
		logic [7:0] b0;
		logic [3:0] z4;
		x9 = 9'(ax);
		y9 = 9'(ay);
		m = {~btn_n[BTN_M], ~btn_n[BTN_R], ~btn_n[BTN_L]};
		z4 = (az > 7) ? 4'h7 : (az < -8) ? 4'h8 : 4'(az);
		b0 = {yv, xv, y9[8], x9[8], 1'b1, m};
		if (emode == MRM_FIVE) b0[7:6] = 2'b00;
		if (usb) begin
			exq.push_back(five ? {3'h0, ~btn_n[BTN_5], ~btn_n[BTN_4], m} : {5'h00, m});
			exq.push_back(s8(ax));
			exq.push_back(s8(-ay));
			exq.push_back(s8(-az));
		end else begin
			exq.push_back(b0);
			exq.push_back(x9[7:0]);
			exq.push_back(y9[7:0]);
			if (emode == MRM_3D) exq.push_back(s8(az));
			if (emode == MRM_FIVE) exq.push_back({2'b00, ~btn_n[BTN_5], ~btn_n[BTN_4], z4});
		end
		@(posedge i_clock);
		rep <= 1'b1;
		@(posedge i_clock);
		rep <= 1'b0;
		drain();
		{ax, ay, az, xv, yv} = '0;
	endtask : report
	task automatic status();
		exq.push_back({1'b0, rem, en, scl, wrp, ~btn_n[BTN_L], ~btn_n[BTN_M], ~btn_n[BTN_R]});
		exq.push_back(res);
		exq.push_back(erate);
		@(posedge i_clock);
		st <= 1'b1;
		@(posedge i_clock);
		st <= 1'b0;
		drain();
	endtask : status
	// Random reports in both host formats, slow host in the later modes
	task automatic burst();
		for (int i = 0; i < 4; i++) begin
			usb <= i[0];
			move(8'($random(seed)), 8'($random(seed)), 8'($random(seed)));
			rnd();
			report();
		end
		usb <= 1'b0;
	endtask : burst
	initial begin
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		`CHK("mode", MRM_STD, mode)
		`CHK("rate", RATE_DEFAULT, rate)
		erate = RATE_DEFAULT;
		emode = MRM_STD;
		rnd();
		status();
		burst();
		repeat (3) move(8'h7F, 8'h81, 8'h00);
		report();
		seq(RATE_FIRST, RATE_FIRST, RATE_END);
		host(CMD_READ_ID, ID_STD);
		`CHK("mode", MRM_STD, mode)
		seq(RATE_FIRST, RATE_3D, RATE_END);
		emode = MRM_3D;
		host(CMD_READ_ID, ID_3D);
		`CHK("mode", MRM_3D, mode)
		`CHK("rate", RATE_END, rate)
		slow <= 1'b1;
		burst();
		status();
		host(CMD_RESET, 8'h00);
		emode = MRM_STD;
		erate = RATE_DEFAULT;
		`CHK("mode", MRM_STD, mode)
		status();
		five <= 1'b1;
		seq(RATE_FIRST, RATE_3D, RATE_END);
		`CHK("mode", MRM_STD, mode)
		seq(RATE_FIRST, RATE_FIRST, RATE_END);
		emode = MRM_FIVE;
		host(CMD_READ_ID, ID_FIVE);
		`CHK("mode", MRM_FIVE, mode)
		burst();
		// Reset in mid-run brings back the power-on state
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (12) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
		`CHK("mode", MRM_STD, mode)
		`CHK("rate", RATE_DEFAULT, rate)
		emode = MRM_STD;
		erate = RATE_DEFAULT;
		status();
		host(CMD_READ_ID, ID_STD);
		close_out();
	end
endmodule : tb_top
